// [common/adsc_consts.svh]
// constant names for the converter sampling/clock control and jump-table block
// assumes inclusion by bare name from package and design files
`ifndef ADSC_CONSTS_SVH
`define ADSC_CONSTS_SVH
`define ADSC_OFS_CTRL 4'h0
`define ADSC_OFS_BASE 4'h4
`define ADSC_OFS_STAT 4'h8
`define ADSC_BIT_ON 15
`define ADSC_BIT_ASYNC 4
`define ADSC_DIV_MSB 2
`define ADSC_DIV_RESET 3'h3
`define ADSC_BASE_RESET 16'h0000
`define ADSC_BASE_MASK 16'hFFFE
`define ADSC_IDX_SHIFT 2
`define ADSC_SYNC_SAMPLE_CLKS 2'h2
`define ADSC_UNMAPPED_READ 32'h0000_0000
`endif

// [common/adsc_pkg.sv]
// types for the converter sampling/clock control block
// assumes adsc_consts.svh is on the include path
package adsc_pkg;
`include "adsc_consts.svh"
    typedef enum logic [1:0] {
        ADSC_IDLE,
        ADSC_TRACK,
        ADSC_SAMPLE,
        ADSC_HOLD
    } adsc_state_t;
endpackage

// [common/adsc_cfg_if.sv]
// configuration carried from the register file to the sampler
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface adsc_cfg_if;
    logic converter_on;
    logic async_en;
    logic [2:0] div_sel;
    logic conv_tick;
    logic sampling;
    modport ctrl (output converter_on, output async_en, output div_sel,
                  input conv_tick, input sampling);
    modport core (input converter_on, input async_en, input div_sel,
                  output conv_tick, output sampling);
endinterface

// [logic/adsc_divider.sv]
// converter clock divider producing a one-cycle tick
// assumes converter_source_clock is a one-cycle enable on clk
`timescale 1ns/100ps
module adsc_divider
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic src_tick,
    input wire logic [2:0] div_sel,
    output logic tick
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (!enable) begin
            nxt_cnt = 3'h0;
        end else if (src_tick) begin
            if (cnt_ff >= div_sel) begin
                nxt_cnt = 3'h0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// [logic/adsc_sampler.sv]
// dedicated sample-and-hold sequencer
// assumes trigger is a one-cycle pulse on clk
`timescale 1ns/100ps
`include "adsc_consts.svh"
module adsc_sampler
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trigger,
    input wire logic single_sar,
    adsc_cfg_if.core cfg
);
    adsc_state_t state_ff;
    adsc_state_t nxt_state;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic async_mode;

    assign async_mode = cfg.async_en & single_sar;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ADSC_IDLE: begin
                if (cfg.converter_on) begin
                    nxt_state = async_mode ? ADSC_TRACK : ADSC_HOLD;
                end
            end
            ADSC_TRACK: begin
                if (trigger) begin
                    nxt_state = ADSC_HOLD;
                end
            end
            ADSC_SAMPLE: begin
                if (cfg.conv_tick) begin
                    nxt_cnt = cnt_ff + 2'h1;
                    if (cnt_ff + 2'h1 == `ADSC_SYNC_SAMPLE_CLKS) begin
                        nxt_state = ADSC_HOLD;
                    end
                end
            end
            ADSC_HOLD: begin
                if (async_mode) begin
                    nxt_state = ADSC_TRACK;
                end else if (trigger) begin
                    nxt_state = ADSC_SAMPLE;
                    nxt_cnt = 2'h0;
                end
            end
        endcase
        if (!cfg.converter_on) begin
            nxt_state = ADSC_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ADSC_IDLE;
            cnt_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign cfg.sampling = (state_ff == ADSC_TRACK) || (state_ff == ADSC_SAMPLE);
endmodule

// [logic/adsc_top.sv]
// converter sampling/clock control registers and jump-table base over Avalon-MM
// assumes pair_ready_flags and trigger are synchronous to clk
`timescale 1ns/100ps
`include "adsc_consts.svh"
module adsc_top
    import adsc_pkg::*;
#(
    parameter int PAIRS = 7
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic converter_source_clock,
    input wire logic trigger,
    input wire logic single_sar,
    input wire logic [PAIRS-1:0] pair_ready_flags,
    output logic converter_on,
    output logic conv_clock_tick,
    output logic sampling
);
    ////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] enc_index(input logic [PAIRS-1:0] flags);
        logic [15:0] idx;
        idx = 16'h0000;
        for (int i = PAIRS - 1; i >= 0; i--) begin
            if (flags[i]) begin
                idx = 16'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old_v;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers
    adsc_cfg_if cfg ();

    logic on_ff;
    logic nxt_on;
    logic async_ff;
    logic nxt_async;
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    logic [15:0] base_ff;
    logic [15:0] nxt_base;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [15:0] ctrl_word;
    logic [15:0] ctrl_new;
    logic [15:0] base_read;
    logic req;

    assign req = (avs_read | avs_write) & ~ack_ff;
    assign ctrl_word = {on_ff, 10'h000, async_ff, 1'b0, div_ff};
    assign ctrl_new = merge16(ctrl_word, avs_writedata, avs_byteenable);
    assign base_read = (base_ff & `ADSC_BASE_MASK)
        + (enc_index(pair_ready_flags) << `ADSC_IDX_SHIFT);

    always_comb begin
        nxt_on = on_ff;
        nxt_async = async_ff;
        nxt_div = div_ff;
        nxt_base = base_ff;
        nxt_ack = req;
        nxt_rdata = rdata_ff;
        if (req && avs_write) begin
            unique case (avs_address)
                `ADSC_OFS_CTRL: begin
                    nxt_on = ctrl_new[`ADSC_BIT_ON];
                    if (!on_ff) begin
                        nxt_async = ctrl_new[`ADSC_BIT_ASYNC];
                        nxt_div = ctrl_new[`ADSC_DIV_MSB:0];
                    end
                end
                `ADSC_OFS_BASE: begin
                    nxt_base = merge16(base_ff, avs_writedata, avs_byteenable)
                        & `ADSC_BASE_MASK;
                end
                default: begin
                end
            endcase
        end else if (req && avs_read) begin
            unique case (avs_address)
                `ADSC_OFS_CTRL: nxt_rdata = {16'h0000, ctrl_word};
                `ADSC_OFS_BASE: nxt_rdata = {16'h0000, base_read};
                `ADSC_OFS_STAT: nxt_rdata = {30'h0, cfg.sampling, on_ff};
                default: nxt_rdata = `ADSC_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_ff <= 1'b0;
            async_ff <= 1'b0;
            div_ff <= `ADSC_DIV_RESET;
            base_ff <= `ADSC_BASE_RESET;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            on_ff <= nxt_on;
            async_ff <= nxt_async;
            div_ff <= nxt_div;
            base_ff <= nxt_base;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // sampling path
    assign cfg.converter_on = on_ff;
    assign cfg.async_en = async_ff;
    assign cfg.div_sel = div_ff;

    adsc_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .enable(on_ff),
        .src_tick(converter_source_clock),
        .div_sel(cfg.div_sel),
        .tick(cfg.conv_tick)
    );

    adsc_sampler u_smp (
        .clk(clk),
        .rst_n(rst_n),
        .trigger(trigger),
        .single_sar(single_sar),
        .cfg(cfg)
    );

    assign converter_on = on_ff;
    assign conv_clock_tick = cfg.conv_tick;
    assign sampling = cfg.sampling;
endmodule

// [sim/adsc_properties.sv]
// checker for the converter control block ports
// assumes bind onto adsc_top, one clock domain
`timescale 1ns/100ps
module adsc_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic converter_on,
    input wire logic conv_clock_tick,
    input wire logic sampling
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire rd_done = avs_read && !avs_waitrequest;
    ////////////////////////////////////////////////////////////////
    a_wait_first: assert property (($rose(avs_read) || $rose(avs_write))
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
    a_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_base_low_zero: assert property (rd_done && avs_address == 4'h4
        |-> avs_readdata[1:0] == 2'h0) else $error("base read low bits set");
    a_base_high_zero: assert property (rd_done && avs_address == 4'h4
        |-> avs_readdata[31:16] == 16'h0000) else $error("base read upper half set");
    a_ctrl_reserved: assert property (rd_done && avs_address == 4'h0
        |-> avs_readdata[14:5] == 10'h000 && !avs_readdata[3]) else $error("ctrl reserved set");
    a_ctrl_on_bit: assert property (rd_done && avs_address == 4'h0
        |-> avs_readdata[15] == converter_on) else $error("ctrl on bit mismatch");
    a_unmapped_zero: assert property (rd_done && !(avs_address inside {4'h0, 4'h4, 4'h8})
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    a_tick_off: assert property (!converter_on && !$past(converter_on)
        && !$past(converter_on, 2) |-> !conv_clock_tick) else $error("tick while off");
    a_reset_quiet: assert property ($rose(rstn) |-> !converter_on && !sampling)
        else $error("outputs active after reset");
    ////////////////////////////////////////////////////////////////
    cover property (rd_done && avs_address == 4'h4 && avs_readdata[4:2] != 3'h0);
    cover property ($rose(sampling));
    cover property ($fell(sampling) && converter_on);
endmodule
bind adsc_top adsc_properties adsc_properties_i (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .converter_on(converter_on), .conv_clock_tick(conv_clock_tick), .sampling(sampling));

// [sim/adsc_top_tb.sv]
// self-checking bench for the converter control block
// assumes adsc_pkg and the checker are compiled beforehand
`timescale 1ns/100ps
module adsc_top_tb import adsc_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic src = 1'b0;
    logic trigger = 1'b0;
    logic single_sar = 1'b0;
    logic [6:0] flags = 7'h00;
    logic converter_on;
    logic conv_clock_tick;
    logic sampling;
    logic [31:0] q;
    int num_errors = 0;
    int checks = 0;
    int n;
    int k;
    // base written, pending flags, expected read
    logic [38:0] rows [10] = '{{16'h1235, 7'h00, 16'h1234}, {16'h1000, 7'h01, 16'h1000},
        {16'h1000, 7'h02, 16'h1004}, {16'h1000, 7'h06, 16'h1004},
        {16'h1000, 7'h0C, 16'h1008}, {16'h2000, 7'h08, 16'h200C},
        {16'h2000, 7'h30, 16'h2010}, {16'h2000, 7'h60, 16'h2014},
        {16'h2000, 7'h40, 16'h2018}, {16'hFF00, 7'h7F, 16'hFF00}};
    always #20 clk = ~clk;
    always @(posedge clk) src <= ~src;
    adsc_top #(.PAIRS(7)) adsc_top_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .converter_source_clock(src), .trigger(trigger), .single_sar(single_sar),
        .pair_ready_flags(flags), .converter_on(converter_on),
        .conv_clock_tick(conv_clock_tick), .sampling(sampling));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       output logic [31:0] rd);
        int w;
        w = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && w < 20) begin
            @(posedge clk);
            w++;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (w >= 20) chk("bus answer", 32'h0, 32'h1);
        @(posedge clk);
    endtask
    task automatic pulse_trigger();
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, 4'h0, 16'h0, q);
        chk("ctrl reset", q, 32'h0000_0003);
        bus(1'b0, 4'h4, 16'h0, q);
        chk("base reset", q, 32'h0000_0000);
        foreach (rows[i]) begin
            flags <= rows[i][22:16];
            bus(1'b1, 4'h4, rows[i][38:23], q);
            bus(1'b0, 4'h4, 16'h0, q);
            chk("base read", q, {16'h0000, rows[i][15:0]});
        end
        flags <= 7'h00;
        bus(1'b1, 4'hC, 16'hFFFF, q);
        bus(1'b0, 4'hC, 16'h0, q);
        chk("unmapped", q, 32'h0000_0000);
        bus(1'b1, 4'h0, 16'h8015, q);
        bus(1'b1, 4'h0, 16'h8002, q);
        bus(1'b0, 4'h0, 16'h0, q);
        chk("guarded ctrl", q, 32'h0000_8015);
        bus(1'b1, 4'h0, 16'h0002, q);
        bus(1'b0, 4'h0, 16'h0, q);
        chk("guarded off", q, 32'h0000_0015);
        single_sar <= 1'b1;
        bus(1'b1, 4'h0, 16'h8015, q);
        repeat (6) @(posedge clk);
        chk("async track", {31'h0, sampling}, 32'h1);
        chk("on pin", {31'h0, converter_on}, 32'h1);
        bus(1'b0, 4'h8, 16'h0, q);
        chk("status track", q, 32'h0000_0003);
        pulse_trigger();
        k = 0;
        repeat (3) begin
            @(posedge clk);
            if (sampling === 1'b0) k = 1;
        end
        chk("async stop", k, 32'h1);
        single_sar <= 1'b0;
        repeat (6) @(posedge clk);
        pulse_trigger();
        repeat (30) @(posedge clk);
        chk("one sar only", {31'h0, sampling}, 32'h0);
        bus(1'b1, 4'h0, 16'h0000, q);
        bus(1'b1, 4'h0, 16'h8000, q);
        repeat (4) @(posedge clk);
        pulse_trigger();
        k = 0;
        repeat (40) begin
            @(posedge clk);
            if (sampling === 1'b1 && conv_clock_tick === 1'b1) k++;
        end
        chk("sync ticks", k, 32'h2);
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, 4'h0, {13'h0, d[2:0]}, q);
            bus(1'b1, 4'h0, {1'b1, 12'h0, d[2:0]}, q);
            n = 0;
            while (conv_clock_tick !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            @(posedge clk);
            n = 1;
            while (conv_clock_tick !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            chk("div gap", n, 2 * (d + 1));
        end
        bus(1'b1, 4'h0, 16'h0000, q);
        bus(1'b1, 4'h4, 16'h1234, q);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("on after reset", {31'h0, converter_on}, 32'h0);
        bus(1'b0, 4'h0, 16'h0, q);
        chk("ctrl re-reset", q, 32'h0000_0003);
        bus(1'b0, 4'h4, 16'h0, q);
        chk("base re-reset", q, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
